/* File: verilog/dfs_top.sv */
// Dynamic fan start temperature loop for three temperature channels.
// Assumes temperatures, hysteresis, trip and range come from same-clock
// logic, and mon_tick marks the end of each monitoring cycle.
`timescale 1ns/1ps
`default_nettype none

module dfs_top (
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic                     mon_tick,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    input  wire dfs_pkg::dfs_chan_in_t [2:0] chan_in,
    output dfs_pkg::dfs_chan_out_t     [2:0] chan_out
);

    typedef struct packed {
        logic [2:0][7:0] op;
        logic [2:0][7:0] lo;
        logic [2:0][7:0] hi;
        logic [2:0][7:0] start;
        logic [2:0][9:0] prev;
        logic [7:0]      ctl1;
        logic [7:0]      ctl2;
        logic [5:0]      status;
        logic [7:0]      rdata;
        logic [2:0][7:0] duty;
        logic [2:0]      full;
    } dfs_state_t;

    dfs_state_t        state_reg;
    dfs_state_t        state_next;

    logic [2:0][2:0]   code;
    logic [2:0]        short_stb;
    logic [2:0]        long_stb;
    logic [2:0]        dyn_en;
    logic [2:0][7:0]   tint;
    logic [2:0][8:0]   band;
    logic [2:0][10:0]  rise;
    logic [2:0][7:0]   dec_s;
    logic [2:0]        dec_l;
    logic [2:0]        inc_l;
    logic [2:0][9:0]   adj;
    logic [2:0][7:0]   diff;
    logic [2:0][15:0]  scaled;
    logic [2:0]        sw_st_wr;
    logic [5:0]        flag_set;
    logic              stat_clr;

    ////////////////////////////////////////////////////////////////
    // Cycle codes and enables from the two control registers
    assign code[0] = state_reg.ctl2[2:0];
    assign code[1] = state_reg.ctl2[5:3];
    // Remote 2 code: high bits in control two, low bit in control one
    assign code[2] = {state_reg.ctl2[7:6],
                      state_reg.ctl1[dfs_pkg::R2_CODE_LSB]};
    assign dyn_en  = state_reg.ctl1[dfs_pkg::EN_LSB +: 3];

    ////////////////////////////////////////////////////////////////
    // One independent cycle timer per channel
    for (genvar g = 0; g < dfs_pkg::NCH; g++) begin : g_tmr
        dfs_cycle_timer #(
            .CODE_W (3),
            .CNT_W  (11)
        ) u_tmr (
            .mclk       (mclk),
            .arst_n     (arst_n),
            .mon_tick   (mon_tick),
            .cycle_code (code[g]),
            .short_stb  (short_stb[g]),
            .long_stb   (long_stb[g])
        );
    end

    ////////////////////////////////////////////////////////////////
    // Software write strobes for the start temperature registers, read strobe of status
    always_comb begin
        sw_st_wr    = '0;
        sw_st_wr[0] = reg_wr && (reg_addr == dfs_pkg::ADDR_ST0);
        sw_st_wr[1] = reg_wr && (reg_addr == dfs_pkg::ADDR_ST1);
        sw_st_wr[2] = reg_wr && (reg_addr == dfs_pkg::ADDR_ST2);
        stat_clr    = reg_rd && (reg_addr == dfs_pkg::ADDR_STAT);
    end

    ////////////////////////////////////////////////////////////////
    // Per-channel loop arithmetic
    always_comb begin
        tint     = '0;
        band     = '0;
        rise     = '0;
        dec_s    = '0;
        dec_l    = '0;
        inc_l    = '0;
        adj      = '0;
        diff     = '0;
        scaled   = '0;
        flag_set = '0;
        for (int i = 0; i < dfs_pkg::NCH; i++) begin
            tint[i] = chan_in[i].temp[9:2];
            // Operating point minus hysteresis, floored at zero
            if (state_reg.op[i] > {4'h0, chan_in[i].hyst}) begin
                band[i] = {1'b0, state_reg.op[i]} - {5'h00, chan_in[i].hyst};
            end
            // Limit checks run on every monitoring cycle
            if (mon_tick && (tint[i] < state_reg.lo[i])) begin
                flag_set[i] = 1'b1;
            end
            if (mon_tick && (tint[i] > state_reg.hi[i])) begin
                flag_set[dfs_pkg::HI_FLAG_LSB + i] = 1'b1;
            end
            // Rise since last short cycle, in quarter degrees
            rise[i] = {1'b0, chan_in[i].temp} - {1'b0, state_reg.prev[i]};
            // Short cycle: only above band and at or above start
            if (dyn_en[i] && short_stb[i]
                && ({1'b0, tint[i]} > band[i])
                && (tint[i] >= state_reg.start[i])
                && !rise[i][10]
                && (rise[i] > 11'h001)) begin
                // Half the quarter-degree rise gives 2 degrees per degree
                if (rise[i][10:1] > 10'h0FF) begin
                    dec_s[i] = 8'hFF;
                end else begin
                    dec_s[i] = rise[i][8:1];
                end
            end
            // Long cycle: decrease above operating point, else may increase
            if (dyn_en[i] && long_stb[i]
                && (tint[i] >= state_reg.start[i])) begin
                if (tint[i] > state_reg.op[i]) begin
                    dec_l[i] = 1'b1;
                end else if ((tint[i] < state_reg.lo[i])
                             && (state_reg.start[i] < state_reg.hi[i])
                             && (state_reg.start[i] < state_reg.op[i])) begin
                    inc_l[i] = 1'b1;
                end
            end
            // Combine, floor at zero; increase is bounded by the high limit
            adj[i] = {2'b00, state_reg.start[i]} - {2'b00, dec_s[i]}
                     - {9'h000, dec_l[i]} + {9'h000, inc_l[i]};
            if (adj[i][9]) begin
                adj[i] = '0;
            end
            // Duty ramp above start: span of 2^(range+1) degrees
            if (tint[i] >= state_reg.start[i]) begin
                diff[i] = tint[i] - state_reg.start[i];
            end
            scaled[i] = {8'h00, diff[i]} << (3'h7 - chan_in[i].range);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Next state: register writes, loop updates, status, outputs
    always_comb begin
        state_next = state_reg;
        // Register writes; unmapped addresses are ignored
        if (reg_wr) begin
            unique case (reg_addr)
                dfs_pkg::ADDR_OP0:  state_next.op[0] = reg_wdata;
                dfs_pkg::ADDR_OP1:  state_next.op[1] = reg_wdata;
                dfs_pkg::ADDR_OP2:  state_next.op[2] = reg_wdata;
                dfs_pkg::ADDR_CTL1: state_next.ctl1  = reg_wdata;
                dfs_pkg::ADDR_CTL2: state_next.ctl2  = reg_wdata;
                dfs_pkg::ADDR_LO0:  state_next.lo[0] = reg_wdata;
                dfs_pkg::ADDR_HI0:  state_next.hi[0] = reg_wdata;
                dfs_pkg::ADDR_LO1:  state_next.lo[1] = reg_wdata;
                dfs_pkg::ADDR_HI1:  state_next.hi[1] = reg_wdata;
                dfs_pkg::ADDR_LO2:  state_next.lo[2] = reg_wdata;
                dfs_pkg::ADDR_HI2:  state_next.hi[2] = reg_wdata;
                default: begin
                end
            endcase
        end
        for (int i = 0; i < dfs_pkg::NCH; i++) begin
            // Software write wins over a same-cycle loop update
            if (sw_st_wr[i]) begin
                state_next.start[i] = reg_wdata;
            end else if (dyn_en[i]) begin
                state_next.start[i] = adj[i][7:0];
            end
            // Disabled channel keeps its programmed start
            // Previous temperature captured at every short cycle
            if (short_stb[i]) begin
                state_next.prev[i] = chan_in[i].temp;
            end
            // Critical trip forces full duty, else saturated ramp
            if (tint[i] > chan_in[i].crit) begin
                state_next.duty[i] = 8'hFF;
                state_next.full[i] = 1'b1;
            end else if (scaled[i][15:8] != 8'h00) begin
                state_next.duty[i] = 8'hFF;
                state_next.full[i] = 1'b0;
            end else begin
                state_next.duty[i] = scaled[i][7:0];
                state_next.full[i] = 1'b0;
            end
        end
        // Sticky flags: read clears, a new event in the same cycle wins
        if (stat_clr) begin
            state_next.status = flag_set;
        end else begin
            state_next.status = state_reg.status | flag_set;
        end
        // Read data registered one cycle after the read strobe
        if (reg_rd) begin
            unique case (reg_addr)
                dfs_pkg::ADDR_OP0:  state_next.rdata = state_reg.op[0];
                dfs_pkg::ADDR_OP1:  state_next.rdata = state_reg.op[1];
                dfs_pkg::ADDR_OP2:  state_next.rdata = state_reg.op[2];
                dfs_pkg::ADDR_CTL1: state_next.rdata = state_reg.ctl1;
                dfs_pkg::ADDR_CTL2: state_next.rdata = state_reg.ctl2;
                dfs_pkg::ADDR_ST0:  state_next.rdata = state_reg.start[0];
                dfs_pkg::ADDR_ST1:  state_next.rdata = state_reg.start[1];
                dfs_pkg::ADDR_ST2:  state_next.rdata = state_reg.start[2];
                dfs_pkg::ADDR_STAT: state_next.rdata = {2'b00, state_reg.status};
                dfs_pkg::ADDR_LO0:  state_next.rdata = state_reg.lo[0];
                dfs_pkg::ADDR_HI0:  state_next.rdata = state_reg.hi[0];
                dfs_pkg::ADDR_LO1:  state_next.rdata = state_reg.lo[1];
                dfs_pkg::ADDR_HI1:  state_next.rdata = state_reg.hi[1];
                dfs_pkg::ADDR_LO2:  state_next.rdata = state_reg.lo[2];
                dfs_pkg::ADDR_HI2:  state_next.rdata = state_reg.hi[2];
                default:            state_next.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // State register; all resets are constants
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg        <= '0;
            state_reg.op     <= {3{dfs_pkg::OP_RST}};
            state_reg.lo     <= {3{dfs_pkg::LO_RST}};
            state_reg.hi     <= {3{dfs_pkg::HI_RST}};
            state_reg.start  <= {3{dfs_pkg::START_RST}};
            state_reg.ctl1   <= dfs_pkg::CTL_RST;
            state_reg.ctl2   <= dfs_pkg::CTL_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign reg_rdata = state_reg.rdata;
    for (genvar g = 0; g < dfs_pkg::NCH; g++) begin : g_out
        assign chan_out[g].start = state_reg.start[g];
        assign chan_out[g].duty  = state_reg.duty[g];
        assign chan_out[g].full  = state_reg.full[g];
    end

endmodule

`default_nettype wire

/* File: inc/dfs_pkg.sv */
// Constants, register map and carrier types of the dynamic fan start loop.
// Assumes one 10 MHz clock and a one-cycle monitoring-cycle tick.
// Behaviour
// - Three 8-bit operating points, reset 0xA4
// - Six 8-bit limits, low 0x01, high 0x7F
// - Below low limit sets status error flag
// - Above high limit sets status error flag
// - Fan starts driving at fan start temperature
// - Adjust start temperature toward operating point
// - Above critical trip, fan runs full duty
// - Range sets duty slope versus temperature
// - Cool zone raises start temperature
// - Hot zone lowers start temperature
// - Below low limit start temperature increases
// - Above operating point start temperature decreases
// - Short cycle every n, long every 2n
// - Remote1 code [2:0], local code [5:3]
// - Remote2 code from [7:6] plus bit 0
// - Short cycle is 8 times 2^k ticks
// - Quiet band leaves start temperature unchanged
// - Disabled channel keeps fixed start and range
// - Enable bits [7:5] gate each channel
// - Short cycle: 2 degrees per degree rise
// - Long cycle above operating point lowers 1
// - Never raise start above high limit

package dfs_pkg;

    localparam int NCH = 3;

    // Register offsets
    localparam logic [7:0] ADDR_OP0   = 8'h33;
    localparam logic [7:0] ADDR_OP1   = 8'h34;
    localparam logic [7:0] ADDR_OP2   = 8'h35;
    localparam logic [7:0] ADDR_CTL1  = 8'h36;
    localparam logic [7:0] ADDR_CTL2  = 8'h37;
    localparam logic [7:0] ADDR_ST0   = 8'h38;
    localparam logic [7:0] ADDR_ST1   = 8'h39;
    localparam logic [7:0] ADDR_ST2   = 8'h3A;
    localparam logic [7:0] ADDR_STAT  = 8'h3B;
    localparam logic [7:0] ADDR_LO0   = 8'h4E;
    localparam logic [7:0] ADDR_HI0   = 8'h4F;
    localparam logic [7:0] ADDR_LO1   = 8'h50;
    localparam logic [7:0] ADDR_HI1   = 8'h51;
    localparam logic [7:0] ADDR_LO2   = 8'h52;
    localparam logic [7:0] ADDR_HI2   = 8'h53;

    // Reset values
    localparam logic [7:0] OP_RST     = 8'hA4;
    localparam logic [7:0] LO_RST     = 8'h01;
    localparam logic [7:0] HI_RST     = 8'h7F;
    localparam logic [7:0] CTL_RST    = 8'h00;
    localparam logic [7:0] START_RST  = 8'h5A;

    // Field positions
    localparam int EN_LSB             = 5;
    localparam int R2_CODE_LSB        = 0;
    localparam int HI_FLAG_LSB        = 3;

    // Cycle timing
    localparam logic [3:0] SHORT_BASE = 4'h8;

    // Temperature in quarter degrees: [9:2] whole, [1:0] fraction
    typedef struct packed {
        logic [9:0] temp;
        logic [3:0] hyst;
        logic [7:0] crit;
        logic [2:0] range;
    } dfs_chan_in_t;

    typedef struct packed {
        logic [7:0] start;
        logic [7:0] duty;
        logic       full;
    } dfs_chan_out_t;

endpackage

/* File: verilog/dfs_cycle_timer.sv */
// Per-channel monitoring-cycle counter giving short and long strobes.
// Assumes mon_tick is a one-cycle pulse from logic on mclk.
`timescale 1ns/1ps
`default_nettype none

module dfs_cycle_timer #(
    parameter int CODE_W = 3,
    parameter int CNT_W  = 11
) (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic              mon_tick,
    input  wire logic [CODE_W-1:0] cycle_code,
    output logic                   short_stb,
    output logic                   long_stb
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } dfs_timer_state_t;

    dfs_timer_state_t state_reg;
    dfs_timer_state_t state_next;
    logic [CNT_W-1:0] short_mask;
    logic [CNT_W-1:0] long_mask;

    // Longest long cycle must fit the counter
    if (CNT_W < (1 << CODE_W) + 3) begin : g_chk
        $error("dfs_cycle_timer: counter too narrow");
    end

    ////////////////////////////////////////////////////////////////
    // Free counter; strobes where low bits are all ones
    always_comb begin
        short_mask = (CNT_W'(dfs_pkg::SHORT_BASE) << cycle_code) - CNT_W'(1);
        long_mask  = {short_mask[CNT_W-2:0], 1'b1}; // Twice the short
        state_next = state_reg;
        if (mon_tick) begin
            state_next.cnt = state_reg.cnt + CNT_W'(1);
        end
        short_stb = mon_tick && ((state_reg.cnt & short_mask) == short_mask);
        long_stb  = mon_tick && ((state_reg.cnt & long_mask) == long_mask);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

`default_nettype wire

/* File: testbench/dfs_top_assertions.sv */
// Port checker of the fan start loop: read port, start updates, trip duty.
// Assumes it is bound to dfs_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module dfs_top_checker (
    input wire logic                         mclk,
    input wire logic                         arst_n,
    input wire logic                         mon_tick,
    input wire logic [7:0]                   reg_addr,
    input wire logic [7:0]                   reg_wdata,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [7:0]                   reg_rdata,
    input wire dfs_pkg::dfs_chan_in_t  [2:0] chan_in,
    input wire dfs_pkg::dfs_chan_out_t [2:0] chan_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Register port: data holds between reads, holes read zero, status clears
    a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h33 || reg_addr > 8'h53
        || (reg_addr > 8'h3B && reg_addr < 8'h4E)) |=> reg_rdata == 8'h00)
        else $error("unmapped read gave nonzero data");
    a_status_clears: assert property (reg_rd && reg_addr == 8'h3B && !mon_tick ##1
        reg_rd && reg_addr == 8'h3B && !mon_tick |=> reg_rdata == 8'h00)
        else $error("status flags survived a read");

    ////////////////////////////////////////////////////////////////////////////////
    // Start temperature moves only after a tick or a write; writes win
    a_start_cause: assert property ($changed(chan_out[0].start)
        || $changed(chan_out[1].start) || $changed(chan_out[2].start)
        |-> $past(mon_tick) || $past(mon_tick, 2) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("start temperature moved without a cause");
    a_start_write: assert property (reg_wr && reg_addr == 8'h38
        |=> chan_out[0].start == $past(reg_wdata))
        else $error("written start temperature not taken");

    ////////////////////////////////////////////////////////////////////////////////
    // Duty and trip output follow the previous cycle's inputs
    a_full_set: assert property ($past(arst_n)
        && $past(chan_in[0].temp[9:2] > chan_in[0].crit)
        |-> chan_out[0].full && chan_out[0].duty == 8'hFF)
        else $error("trip exceeded without full duty");
    a_full_clear: assert property ($past(arst_n)
        && $past(chan_in[1].temp[9:2] < chan_in[1].crit) |-> !chan_out[1].full)
        else $error("full duty below the trip");
    a_full_duty: assert property (chan_out[0].full |-> chan_out[0].duty == 8'hFF
        && $past(chan_in[0].temp[9:2] > chan_in[0].crit))
        else $error("full flag without trip or full duty");
    a_duty_zero: assert property ($past(arst_n)
        && $past(chan_in[1].temp[9:2] < chan_out[1].start
        && chan_in[1].temp[9:2] < chan_in[1].crit) |-> chan_out[1].duty == 8'h00)
        else $error("fan driven below start temperature");

    // Main scenarios: loop update, status double read, trip
    cover property ($changed(chan_out[1].start) && !$past(reg_wr));
    cover property (reg_rd && reg_addr == 8'h3B ##1 reg_rd);
    cover property (chan_out[0].full);
endmodule

`default_nettype wire

/* File: testbench/dfs_top_test.sv */
// Self-checking bench of the fan start loop, driving all ports directly.
// Assumes dfs_pkg is compiled first; binds the port checker to dfs_top.
`timescale 1ns/1ps
`default_nettype none

module dfs_top_test;
    logic                         mclk;
    logic                         arst_n;
    logic                         mon_tick;
    logic [7:0]                   reg_addr;
    logic [7:0]                   reg_wdata;
    logic                         reg_wr;
    logic                         reg_rd;
    logic [7:0]                   reg_rdata;
    dfs_pkg::dfs_chan_in_t  [2:0] chan_in;
    dfs_pkg::dfs_chan_out_t [2:0] chan_out;
    int                           n_mismatch;
    int                           cmp_count;
    logic [7:0]                   rv;
    // Reset table: addresses and values, one hole at the end reads zero
    localparam logic [7:0] RA [16] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A,
        8'h3B, 8'h4E, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h53, 8'h40};
    localparam logic [7:0] RE [16] = '{8'hA4, 8'hA4, 8'hA4, 8'h00, 8'h00, 8'h5A, 8'h5A, 8'h5A,
        8'h00, 8'h01, 8'h7F, 8'h01, 8'h7F, 8'h01, 8'h7F, 8'h00};

    dfs_top i_dfs_top (.mclk(mclk), .arst_n(arst_n), .mon_tick(mon_tick), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .chan_in(chan_in), .chan_out(chan_out));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 10 MHz
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks: all start and end 1 ns after a rising edge, one idle cycle between strobes
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1 reg_wr = 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
        @(posedge mclk);
        #1;
    endtask

    // Ticks are spaced so the loop result lands before the next check
    task automatic tick(input int n);
        repeat (n) begin
            mon_tick = 1'b1;
            @(posedge mclk);
            #1 mon_tick = 1'b0;
            @(posedge mclk);
            #1;
        end
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic st(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
        chk("start ch0", e0, chan_out[0].start);
        chk("start ch1", e1, chan_out[1].start);
        chk("start ch2", e2, chan_out[2].start);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard: a stuck run counts as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        $display("[ERR] run length expected done seen hang");
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        mon_tick = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        for (int i = 0; i < 3; i++) chan_in[i] = '{10'h000, 4'h4, 8'hFF, 3'h0};
        arst_n = 1'b0;
        repeat (8) @(posedge mclk);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd(RA[i], rv);
            chk($sformatf("reg %h", RA[i]), RE[i], rv);
        end
        // Ch0 hot above a low high limit, ch1 cool below its low limit, ch2 hot
        wr(8'h33, 8'h50);
        wr(8'h4F, 8'h60);
        wr(8'h34, 8'h70);
        wr(8'h50, 8'h60);
        wr(8'h35, 8'h50);
        wr(8'h36, 8'h01);
        rd(8'h33, rv);
        chk("op ch0", 8'h50, rv);
        chan_in[0].temp = 10'h190;
        chan_in[1].temp = 10'h170;
        chan_in[2].temp = 10'h190;
        tick(16);
        st(8'h5A, 8'h5A, 8'h5A);
        // Back-to-back status reads: flags, then cleared
        reg_addr = 8'h3B;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1 chk("status", 8'h0A, reg_rdata);
        @(posedge mclk);
        #1 reg_rd = 1'b0;
        chk("status cleared", 8'h00, reg_rdata);
        @(posedge mclk);
        #1;
        // Enable all channels; ch2 keeps its split code of one
        wr(8'h36, 8'hE1);
        tick(8);
        st(8'h5A, 8'h5A, 8'h5A);
        tick(8);
        st(8'h59, 8'h5B, 8'h59);
        chan_in[0].temp = 10'h194;
        tick(8);
        st(8'h57, 8'h5B, 8'h59);
        tick(8);
        st(8'h56, 8'h5C, 8'h59);
        // High limit caps the increase of ch1
        wr(8'h51, 8'h5C);
        tick(16);
        st(8'h55, 8'h5C, 8'h58);
        rd(8'h39, rv);
        chk("start reg ch1", 8'h5C, rv);
        wr(8'h38, 8'h40);
        rd(8'h38, rv);
        chk("start reg ch0", 8'h40, rv);
        // Trip on ch0, shallowest slope on ch2: 12 degrees over start gives 0C
        chan_in[0].crit = 8'h50;
        chan_in[2].range = 3'h7;
        repeat (2) @(posedge mclk);
        #1 chk("full ch0", 8'h01, {7'h00, chan_out[0].full});
        chk("duty ch0", 8'hFF, chan_out[0].duty);
        chk("duty ch2", 8'h0C, chan_out[2].duty);
        // Distinct codes: ch0 code 2 gets no long cycle, ch1 code 1 gets one
        wr(8'h51, 8'h7F);
        wr(8'h37, 8'h0A);
        rd(8'h37, rv);
        chk("cycle codes", 8'h0A, rv);
        tick(32);
        st(8'h40, 8'h5D, 8'h57);
        finish_test();
    end
endmodule

bind dfs_top dfs_top_checker i_dfs_top_checker (.mclk(mclk), .arst_n(arst_n),
    .mon_tick(mon_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_in(chan_in), .chan_out(chan_out));

`default_nettype wire
